// *** rtl/asrr_chk.v ***
/*
 * Combinational access checker: address decode and misalignment test.
 * Assumes access fields are stable and from logic on the same clock.
 */
`include "asrr_defs.vh"

module asrr_chk #(
  parameter [7:0] FLASH_AREA = 8'h01
) (
  // Access under test
  input wire [31:0] addr,
  input wire [1:0] size,
  input wire [1:0] acc_type,
  input wire from_cpu,
  input wire remap,
  // Verdict
  output reg undef,
  output reg misal,
  output reg [1:0] target
);

  always @* begin
    undef = 1'b0;
    target = `ASRR_TGT_NONE;
    if (addr[31:28] == `ASRR_REGION_PERIPH) begin
      target = `ASRR_TGT_PERIPH;
    end else if (addr[31:28] == `ASRR_REGION_INTERNAL) begin
      if (addr[27:20] == `ASRR_AREA_ZERO) begin
        target = remap ? `ASRR_TGT_SRAM : `ASRR_TGT_FLASH;
      end else if (addr[27:20] == `ASRR_AREA_SRAM) begin
        target = `ASRR_TGT_SRAM;
      end else if (addr[27:20] == FLASH_AREA) begin
        target = `ASRR_TGT_FLASH;
      end else begin
        undef = 1'b1;
      end
    end else begin
      undef = 1'b1;
    end
  end

  always @* begin
    misal = 1'b0;
    // Processor fetches are never checked for alignment
    if (!(from_cpu && acc_type == `ASRR_TYPE_FETCH)) begin
      if (size == `ASRR_SIZE_WORD && addr[1:0] != 2'h0) begin
        misal = 1'b1;
      end else if (size == `ASRR_SIZE_HALF && addr[0]) begin
        misal = 1'b1;
      end
    end
  end

endmodule // asrr_chk

// *** rtl/asrr_defs.vh ***
/*
 * Offsets, field positions, reset values and codes for the abort status
 * and remap register bank.
 * Assumes a byte-addressed register port with 8 address bits and
 * 32-bit data.
 */
`ifndef ASRR_DEFS_VH
`define ASRR_DEFS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ASRR_OFF_REMAP 8'h00
`define ASRR_OFF_STATUS 8'h04
`define ASRR_OFF_ADDR 8'h08
`define ASRR_OFF_IRQ_STAT 8'h0C
`define ASRR_OFF_IRQ_MASK 8'h80

// ****************************************************************
// Abort status and remap fields and reset values
// ****************************************************************
`define ASRR_BIT_UNDEF 0
`define ASRR_BIT_MISAL 1
`define ASRR_SIZE_LO 8
`define ASRR_TYPE_LO 10
`define ASRR_SRC_LO 16
`define ASRR_SAVED_LO 24
`define ASRR_BIT_REMAP 0
`define ASRR_STATUS_RESET 32'h00000000
`define ASRR_ADDR_RESET 32'h00000000

// ****************************************************************
// Access codes
// ****************************************************************
`define ASRR_SIZE_BYTE 2'h0
`define ASRR_SIZE_HALF 2'h1
`define ASRR_SIZE_WORD 2'h2
`define ASRR_TYPE_READ 2'h0
`define ASRR_TYPE_WRITE 2'h1
`define ASRR_TYPE_FETCH 2'h2
// Master one-hot bit positions
`define ASRR_MST_ETH 0
`define ASRR_MST_DMA 1
`define ASRR_MST_CPU 2

// ****************************************************************
// Memory map
// ****************************************************************
`define ASRR_REGION_INTERNAL 4'h0
`define ASRR_REGION_PERIPH 4'hF
`define ASRR_AREA_ZERO 8'h00
`define ASRR_AREA_SRAM 8'h02
`define ASRR_TGT_FLASH 2'h0
`define ASRR_TGT_SRAM 2'h1
`define ASRR_TGT_PERIPH 2'h2
`define ASRR_TGT_NONE 2'h3

`endif

// *** rtl/asrr_top.v ***
/*
 * Abort status and remap register bank with interrupt status and mask.
 * Assumes the bus arbiter presents one granted access per cycle, with a
 * one-hot master indication, from logic on sys_clk.
 */
`include "asrr_defs.vh"

module asrr_top #(
  parameter [7:0] FLASH_AREA = 8'h01
) (
  // Clock and reset
  input wire sys_clk,
  input wire arst_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Granted bus access
  input wire acc_valid,
  input wire [31:0] acc_addr,
  input wire [1:0] acc_size,
  input wire [1:0] acc_type,
  input wire [2:0] acc_master,
  // Access verdict
  output reg acc_abort,
  output reg [1:0] acc_target,
  output reg remap_active,
  // Interrupt
  output reg irq
);

  // ****************************************************************
  // Register decode
  // ****************************************************************
  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  wire wr_remap = reg_wr && hit(reg_addr, `ASRR_OFF_REMAP);
  wire wr_irq_stat = reg_wr && hit(reg_addr, `ASRR_OFF_IRQ_STAT);
  wire wr_irq_mask = reg_wr && hit(reg_addr, `ASRR_OFF_IRQ_MASK);
  wire rd_status = reg_rd && hit(reg_addr, `ASRR_OFF_STATUS);

  // ****************************************************************
  // State
  // ****************************************************************
  reg remap_reg;
  reg undef_reg;
  reg misal_reg;
  reg [1:0] size_reg;
  reg [1:0] type_reg;
  reg [2:0] src_reg;
  reg [2:0] saved_reg;
  reg [31:0] abort_addr_reg;
  reg fresh_reg;
  reg [1:0] irq_stat_reg;
  reg [1:0] irq_mask_reg;

  wire chk_undef;
  wire chk_misal;
  wire [1:0] chk_target;

  asrr_chk #(
    .FLASH_AREA(FLASH_AREA)
  ) u_chk (
    .addr(acc_addr),
    .size(acc_size),
    .acc_type(acc_type),
    .from_cpu(acc_master[`ASRR_MST_CPU]),
    .remap(remap_reg),
    .undef(chk_undef),
    .misal(chk_misal),
    .target(chk_target)
  );

  wire abort_now = acc_valid && (chk_undef || chk_misal);
  // Reserved size code is folded onto word so it is never recorded
  wire [1:0] size_rec = (acc_size == 2'h3) ? `ASRR_SIZE_WORD : acc_size;

  // ****************************************************************
  // Remap toggle
  // ****************************************************************
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      remap_reg <= 1'b0;
    end else if (wr_remap && reg_wdata[`ASRR_BIT_REMAP]) begin
      remap_reg <= ~remap_reg;
    end
  end

  // ****************************************************************
  // Abort record
  // ****************************************************************
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      undef_reg <= 1'b0;
      misal_reg <= 1'b0;
      size_reg <= 2'h0;
      type_reg <= 2'h0;
      src_reg <= 3'h0;
      abort_addr_reg <= `ASRR_ADDR_RESET;
    end else if (abort_now) begin
      undef_reg <= chk_undef;
      misal_reg <= chk_misal;
      size_reg <= size_rec;
      type_reg <= acc_type;
      src_reg <= acc_master;
      abort_addr_reg <= acc_addr;
    end
  end

  // The source of a record displaced before software saw it is ORed into saved bits.
  // A read in an abort cycle returns the displaced record, so it clears.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      saved_reg <= 3'h0;
      fresh_reg <= 1'b0;
    end else begin
      if (abort_now) begin
        fresh_reg <= 1'b1;
      end else if (rd_status) begin
        fresh_reg <= 1'b0;
      end
      if (abort_now && fresh_reg && !rd_status) begin
        saved_reg <= saved_reg | src_reg;
      end else if (rd_status) begin
        saved_reg <= 3'h0;
      end
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
      irq <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      irq_stat_reg <= (irq_stat_reg & ~(wr_irq_stat ? reg_wdata[1:0] : 2'h0))
                      | (abort_now ? {chk_misal, chk_undef} : 2'h0);
      if (wr_irq_mask) begin
        irq_mask_reg <= reg_wdata[1:0];
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  wire [31:0] status_word = {5'h00, saved_reg, 5'h00, src_reg, 4'h0,
                             type_reg, size_reg, 6'h00, misal_reg,
                             undef_reg};

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      // Remap control is write-only and reads as zero
      if (hit(reg_addr, `ASRR_OFF_STATUS)) begin
        reg_rdata <= status_word;
      end else if (hit(reg_addr, `ASRR_OFF_ADDR)) begin
        reg_rdata <= abort_addr_reg;
      end else if (hit(reg_addr, `ASRR_OFF_IRQ_STAT)) begin
        reg_rdata <= {30'h00000000, irq_stat_reg};
      end else if (hit(reg_addr, `ASRR_OFF_IRQ_MASK)) begin
        reg_rdata <= {30'h00000000, irq_mask_reg};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ****************************************************************
  // Verdict outputs
  // ****************************************************************
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_abort <= 1'b0;
      acc_target <= `ASRR_TGT_NONE;
      remap_active <= 1'b0;
    end else begin
      acc_abort <= abort_now;
      acc_target <= acc_valid ? chk_target : `ASRR_TGT_NONE;
      remap_active <= remap_reg;
    end
  end

endmodule // asrr_top

// *** testbench/asrr_bus_masters.sv ***
/* Model of the granted bus masters: ethernet, dma, processor.
   Assumes the bench issues one access at a time. */
module asrr_bus_masters (
  // Clock
  input logic clk,
  // Granted access
  output logic acc_valid = 1'b0,
  output logic [31:0] acc_addr = 32'h0,
  output logic [1:0] acc_size = 2'h0,
  output logic [1:0] acc_type = 2'h0,
  output logic [2:0] acc_master = 3'h0
);
  // Idle bus shows the inverse of address, size and master, so stale values never look valid
  task automatic issue(input logic [31:0] a, input logic [1:0] s,
    input logic [1:0] t, input logic [2:0] m);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_size <= s;
    acc_type <= t;
    acc_master <= m;
    @(posedge clk);
    acc_valid <= 1'b0;
    acc_addr <= ~a;
    acc_size <= ~s;
    acc_master <= ~m;
  endtask
endmodule // asrr_bus_masters

// *** testbench/asrr_top_chk.sv ***
/* Port assertions for the abort status and remap bank.
   Assumes it is bound into asrr_top, all on sys_clk. */
module asrr_top_chk (
  // Clock and reset
  input logic sys_clk,
  input logic arst_n,
  // Register port
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  // Access port
  input logic acc_valid,
  input logic [31:0] acc_addr,
  input logic [1:0] acc_size,
  input logic [1:0] acc_type,
  input logic [2:0] acc_master,
  input logic acc_abort,
  input logic [1:0] acc_target,
  input logic remap_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ****************
  // Assertions
  // ****************
  AST_UNDEF: assert property (
    acc_valid && acc_addr[31:28] inside {[4'h1:4'hE]}
    |=> acc_abort && acc_target == 2'h3) else $error("undefined no abort");
  AST_MISAL_WORD: assert property (
    acc_valid && acc_size == 2'h2 && acc_addr[1:0] != 2'h0 &&
    !(acc_master[2] && acc_type == 2'h2) |=> acc_abort)
    else $error("misaligned word not aborted");
  AST_MISAL_HALF: assert property (
    acc_valid && acc_size == 2'h1 && acc_addr[0] && acc_type != 2'h2
    |=> acc_abort) else $error("misaligned half not aborted");
  AST_FETCH_FREE: assert property (
    acc_valid && acc_master == 3'h4 && acc_type == 2'h2 &&
    acc_addr[31:28] == 4'hF |=> !acc_abort && acc_target == 2'h2)
    else $error("processor fetch aborted");
  AST_ABORT_CAUSE: assert property (
    acc_abort |-> $past(acc_valid)) else $error("abort without access");
  AST_REMAP_FLIP: assert property (
    reg_wr && reg_addr == 8'h00 && reg_wdata[0] |-> ##2 $changed(remap_active))
    else $error("remap did not toggle");
  AST_REMAP_KEEP: assert property (
    reg_wr && reg_addr == 8'h00 && !reg_wdata[0] |-> ##2 $stable(remap_active))
    else $error("remap moved on zero write");
  AST_SRAM_HOME: assert property (
    acc_valid && acc_addr[31:20] == 12'h002 && acc_size == 2'h0
    |=> acc_target == 2'h1) else $error("sram home not decoded");
  AST_ZERO_AREA: assert property (
    acc_valid && acc_addr[31:20] == 12'h000 && acc_size == 2'h0
    |=> acc_target == {1'b0, remap_active}) else $error("area zero wrong");
  AST_RESV_ZERO: assert property (
    reg_rd && (reg_addr == 8'h00 || reg_addr inside {[8'h10:8'h5C]})
    |=> reg_rdata == 32'h0) else $error("reserved read not zero");
  AST_CODES: assert property (
    reg_rd && reg_addr == 8'h04 |=> reg_rdata[9:8] != 2'h3 &&
    reg_rdata[11:10] != 2'h3) else $error("reserved code seen");
endmodule // asrr_top_chk

bind asrr_top asrr_top_chk u_port_chk (.sys_clk, .arst_n, .reg_addr,
  .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .acc_valid, .acc_addr, .acc_size,
  .acc_type, .acc_master, .acc_abort, .acc_target, .remap_active);

// *** testbench/test_abort_status_remap_regs.sv ***
/* Register and access tests for the abort status and remap bank.
   Assumes asrr_top with its checker bound and the master model. */
module test_abort_status_remap_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, acc_addr;
  logic acc_valid, acc_abort, remap_active, irq;
  logic [1:0] acc_size, acc_type, acc_target;
  logic [2:0] acc_master;
  int err_count = 0;
  int check_count = 0;
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
  always #20 sys_clk = ~sys_clk;
  asrr_top DUT (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .acc_valid, .acc_addr, .acc_size, .acc_type,
    .acc_master, .acc_abort, .acc_target, .remap_active, .irq);
  asrr_bus_masters u_mst (.clk(sys_clk), .acc_valid, .acc_addr,
    .acc_size, .acc_type, .acc_master);
  // ****************
  // Access tasks
  // ****************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK($sformatf("reg %h", a), e, reg_rdata)
  endtask
  task automatic acc(input logic [31:0] a, input logic [1:0] s,
    input logic [1:0] t, input logic [2:0] m, input logic ab);
    u_mst.issue(a, s, t, m);
    #1;
    `CHK("abort", ab, acc_abort)
  endtask
  // Waits past the next edge; callers compare after it
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    rc(8'h04, 32'h0);
    rc(8'h08, 32'h0);
    rc(8'h00, 32'h0);
    rc(8'h20, 32'h0);
    wr(8'h04, 32'hFFFFFFFF);
    wr(8'h08, 32'hFFFFFFFF);
    rc(8'h04, 32'h0);
    rc(8'h08, 32'h0);
    $display("test reset done");
    acc(32'h12345678, 2'h0, 2'h0, 3'h4, 1'b1);
    rc(8'h04, 32'h00040001);
    rc(8'h08, 32'h12345678);
    `CHK("irq masked", 1'b0, irq)
    wr(8'h80, 32'h1);
    tick();
    `CHK("irq on", 1'b1, irq)
    wr(8'h0C, 32'h1);
    tick();
    `CHK("irq off", 1'b0, irq)
    $display("test undefined done");
    acc(32'h00200002, 2'h2, 2'h1, 3'h2, 1'b1);
    acc(32'hFFFFF001, 2'h1, 2'h2, 3'h1, 1'b1);
    rc(8'h04, 32'h02010902);
    rc(8'h04, 32'h00010902);
    rc(8'h08, 32'hFFFFF001);
    acc(32'h00100002, 2'h2, 2'h2, 3'h4, 1'b0);
    rc(8'h04, 32'h00010902);
    acc(32'hF0000002, 2'h2, 2'h2, 3'h4, 1'b0);
    `CHK("target", 2'h2, acc_target)
    acc(32'h30000003, 2'h2, 2'h0, 3'h4, 1'b1);
    rc(8'h04, 32'h00040203);
    acc(32'h20000000, 2'h0, 2'h0, 3'h1, 1'b1);
    // Abort and status read land on the same edge
    fork
      acc(32'h40000000, 2'h0, 2'h1, 3'h2, 1'b1);
      rc(8'h04, 32'h00010001);
    join
    rc(8'h04, 32'h00020401);
    $display("test misaligned done");
    wr(8'h00, 32'h0);
    tick();
    `CHK("remap", 1'b0, remap_active)
    acc(32'h0, 2'h0, 2'h0, 3'h4, 1'b0);
    `CHK("target", 2'h0, acc_target)
    wr(8'h00, 32'h1);
    tick();
    `CHK("remap", 1'b1, remap_active)
    acc(32'h0, 2'h0, 2'h0, 3'h4, 1'b0);
    `CHK("target", 2'h1, acc_target)
    acc(32'h00200000, 2'h0, 2'h1, 3'h1, 1'b0);
    `CHK("target", 2'h1, acc_target)
    wr(8'h00, 32'h1);
    tick();
    `CHK("remap", 1'b0, remap_active)
    $display("test remap done");
    complete_run();
  end
endmodule // test_abort_status_remap_regs
